/* rtl/efmt_pkg.sv */
// Purpose: shared constants and types of the expansion port formatter
// Assumes: one line-locked clock, 525-line timing
// Notes:   registers are one 32-bit apb word each
`default_nettype none
package efmt_pkg;
  // line timing in bytes and lines
  localparam int unsigned EFMT_ACT_BYTES   = 1440;
  localparam int unsigned EFMT_BLANK_BYTES = 268;
  localparam int unsigned EFMT_CODE_BYTES  = 4;
  localparam int unsigned EFMT_LINES       = 525;
  localparam int unsigned EFMT_ADC_W       = 10;
  // vertical pattern of a 525-line frame
  localparam logic [9:0] EFMT_F2_END   = 10'h003;
  localparam logic [9:0] EFMT_F2_BEG   = 10'h10A;
  localparam logic [9:0] EFMT_V1_END   = 10'h013;
  localparam logic [9:0] EFMT_V2_BEG   = 10'h108;
  localparam logic [9:0] EFMT_V2_END   = 10'h11A;
  localparam logic [9:0] EFMT_LINE_RST = 10'h001;
  // register offsets
  localparam logic [7:0] EFMT_A_OUTFMT = 8'h00;
  localparam logic [7:0] EFMT_A_LTYPE  = 8'h04;
  localparam logic [7:0] EFMT_A_GAIN   = 8'h08;
  localparam logic [7:0] EFMT_A_OFFS   = 8'h0C;
  localparam logic [7:0] EFMT_A_GSTART = 8'h10;
  localparam logic [7:0] EFMT_A_GSTOP  = 8'h14;
  localparam logic [7:0] EFMT_A_CFG    = 8'h18;
  localparam logic [7:0] EFMT_A_STAT   = 8'h1C;
  // reset values
  localparam logic [7:0] EFMT_GAIN_RST = 8'h80;
  localparam logic [7:0] EFMT_OFFS_RST = 8'h80;
  localparam logic [9:0] EFMT_GSTART_RST = 10'h014;
  localparam logic [9:0] EFMT_GSTOP_RST  = 10'h105;
  localparam logic [7:0] EFMT_LTYPE_RST = 8'hF0;
  // output format select codes
  localparam logic [2:0] EFMT_OF_NOCODE = 3'h2;
  localparam logic [2:0] EFMT_OF_GATE   = 3'h1;
  // data types and fixed bytes
  localparam logic [3:0] EFMT_DT_TEST = 4'h6;
  localparam logic [3:0] EFMT_DT_ACT  = 4'hF;
  localparam logic [7:0] EFMT_BLK_LO  = 8'h80;
  localparam logic [7:0] EFMT_BLK_HI  = 8'h10;
  localparam logic [7:0] EFMT_PRE_FF  = 8'hFF;
  localparam logic [7:0] EFMT_PRE_00  = 8'h00;

  typedef enum logic [1:0] {
    ST_EAV   = 2'b00,
    ST_BLANK = 2'b01,
    ST_SAV   = 2'b11,
    ST_ACT   = 2'b10
  } efmt_state_e;

  typedef struct packed {
    logic       psel;
    logic       penable;
    logic       pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } efmt_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } efmt_apb_rsp_s;

  typedef struct packed {
    logic [7:0] lumaProc;
    logic [7:0] lumaBypass;
    logic [7:0] chroma;
    logic [7:0] cvbs;
    logic [EFMT_ADC_W-1:0] adcA;
    logic [EFMT_ADC_W-1:0] adcB;
  } efmt_video_s;

  typedef struct packed {
    logic f;
    logic v;
  } efmt_fv_s;

  // raw sample types: 0 to 5 and 7 to 14
  function automatic logic efmt_is_raw(input logic [3:0] t);
    return (t != EFMT_DT_TEST) && (t != EFMT_DT_ACT);
  endfunction
endpackage
`default_nettype wire

/* rtl/efmt_raw_scale.sv */
// Purpose: gain and offset for composite samples in raw mode
// Assumes: gain 80h is unity, offset 80h is no shift
// Notes:   result clamped to 01h..FEh to keep clear of sync codes
`default_nettype none
module efmt_raw_scale
  import efmt_pkg::*;
(
  input  wire logic [7:0] cvbs,
  input  wire logic [7:0] gain,
  input  wire logic [7:0] offset,
  output logic      [7:0] scaled
);
  logic [15:0] prod;
  logic [9:0]  sum;

  always_comb
  begin
    prod = cvbs * gain;
    sum  = {2'b00, prod[14:7]} + {2'b00, offset} - 10'h080;
    if (prod[15])
      sum = {2'b00, offset} + 10'h07F;
    if (sum[9])
      scaled = 8'h01;
    else if (sum[8] || (sum[7:0] == 8'hFF))
      scaled = 8'hFE;
    else if (sum[7:0] == 8'h00)
      scaled = 8'h01;
    else
      scaled = sum[7:0];
  end
endmodule // efmt_raw_scale
`default_nettype wire

/* rtl/efmt_vflags.sv */
// Purpose: field and vertical blanking flags for a line number
// Assumes: lines numbered 1 to 525
// Notes:   field flag never depends on the gate mode
`default_nettype none
module efmt_vflags
  import efmt_pkg::*;
(
  input  wire logic [9:0] lineNo,
  input  wire logic [2:0] outFmt,
  input  wire logic [9:0] gateStart,
  input  wire logic [9:0] gateStop,
  output efmt_fv_s        fv
);
  logic inGate;

  always_comb
  begin
    inGate = (lineNo >= gateStart) && (lineNo <= gateStop);
    fv.f = (lineNo <= EFMT_F2_END) || (lineNo >= EFMT_F2_BEG);
    if (outFmt == EFMT_OF_GATE)
      fv.v = !inGate;
    else
      fv.v = (lineNo <= EFMT_V1_END) ||
             ((lineNo >= EFMT_V2_BEG) && (lineNo <= EFMT_V2_END));
  end
endmodule // efmt_vflags
`default_nettype wire

/* rtl/efmt_formatter.sv */
// Purpose: byte-serial video output formatter of the expansion port
// Assumes: mclk is the line-locked pixel clock, inputs on mclk
// Notes:   apb slave with zero wait states
//
// Behaviour
// - test-line type takes luma that bypassed comb, peaking and trap
// - raw types put composite samples in Y slots, chroma as test-line
// - composite samples scaled by 8-bit gain and shifted by 8-bit offset
// - top format bit set ignores line types, enters ADC test output
// - test output sends upper or lower 8 ADC bits per format bit 0
// - luma/chroma input multiplexes both ADCs, composite sends only one
// - test output carries no timing reference codes
// - blanking between EAV and SAV repeats 80h then 10h
// - field and vertical bits change only at an EAV code
// - format 010 replaces timing codes with 80h/10h blanking
// - raw or sliced line types send composite instead of luma
// - code bit 7 is one, bit 6 is the field flag
// - code bit 5 is one in vertical blanking, zero in active lines
// - code bit 4 is zero for SAV, one for EAV
// - low four code bits are protection bits, receiver ignores them
// - field bit follows the fixed line pattern in every mode
// - 525 lines: fixed field and standard vertical line patterns
// - format 001 takes vertical bit from the gate start/stop window
// - in test output the LSB of the converter being sent also drives aux status pin
`default_nettype none
module efmt_formatter
  import efmt_pkg::*;
#(
  parameter int unsigned ACT_BYTES   = EFMT_ACT_BYTES,
  parameter int unsigned BLANK_BYTES = EFMT_BLANK_BYTES,
  parameter int unsigned LINES       = EFMT_LINES
)
(
  input  wire logic          mclk,
  input  wire logic          srst,
  input  wire efmt_apb_req_s apbReq,
  output efmt_apb_rsp_s      apbRsp,
  input  wire efmt_video_s   video,
  output logic [7:0]         videoOutputByteBus,
  output logic               auxRealtimeStatusPin
);
  localparam logic [10:0] ACT_LAST   = 11'(ACT_BYTES - 1);
  localparam logic [10:0] BLANK_LAST = 11'(BLANK_BYTES - 1);
  localparam logic [10:0] CODE_LAST  = 11'(EFMT_CODE_BYTES - 1);
  localparam logic [9:0]  LINE_LAST  = 10'(LINES);

  typedef struct packed {
    logic [2:0] outFmt;
    logic [7:0] lineType;
    logic [7:0] gain;
    logic [7:0] offset;
    logic [9:0] gateStart;
    logic [9:0] gateStop;
    logic       lumaChroma;
  } efmt_regs_s;

  typedef struct packed {
    efmt_regs_s  regs;
    efmt_state_e st;
    logic [10:0] cnt;
    logic [9:0]  lineNo;
    efmt_fv_s    fv;
    logic [7:0]  vob;
    logic        aux;
    logic        adcPh;
    logic [31:0] prdata;
  } efmt_q_s;

  localparam efmt_q_s Q_RST = '{
    regs: '{outFmt: 3'h0, lineType: EFMT_LTYPE_RST,
            gain: EFMT_GAIN_RST, offset: EFMT_OFFS_RST,
            gateStart: EFMT_GSTART_RST, gateStop: EFMT_GSTOP_RST,
            lumaChroma: 1'b0},
    st: ST_EAV, cnt: 11'h000, lineNo: EFMT_LINE_RST,
    fv: '{f: 1'b1, v: 1'b1}, vob: EFMT_BLK_LO, aux: 1'b0,
    adcPh: 1'b0, prdata: 32'h0000_0000};

  efmt_q_s q;
  efmt_q_s next_q;

  logic [9:0]  nextLine;
  efmt_fv_s    nextFv;
  logic [7:0]  rawY;
  logic        addrHit;
  logic        wrEn;
  logic        testMode;
  logic        codesOn;
  logic [3:0]  curType;
  logic [7:0]  yByte;
  logic [7:0]  codeByte;
  logic [7:0]  fillByte;
  logic [EFMT_ADC_W-1:0] adcWord;
  logic [7:0]  adcByte;

  efmt_vflags u_vflags (
    .lineNo    (nextLine),
    .outFmt    (q.regs.outFmt),
    .gateStart (q.regs.gateStart),
    .gateStop  (q.regs.gateStop),
    .fv        (nextFv)
  );

  efmt_raw_scale u_raw (
    .cvbs   (video.cvbs),
    .gain   (q.regs.gain),
    .offset (q.regs.offset),
    .scaled (rawY)
  );

  function automatic logic efmt_hit(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= EFMT_A_STAT);
  endfunction

  always_comb
  begin
    addrHit  = efmt_hit(apbReq.paddr);
    wrEn     = apbReq.psel && apbReq.penable && apbReq.pwrite && addrHit;
    nextLine = (q.lineNo == LINE_LAST) ? EFMT_LINE_RST :
               q.lineNo + 10'h001;
    testMode = q.regs.outFmt[2];
    codesOn  = !testMode && (q.regs.outFmt != EFMT_OF_NOCODE);
    curType  = q.fv.v ? q.regs.lineType[3:0] : q.regs.lineType[7:4];
    if (efmt_is_raw(curType))
      yByte = rawY;
    else if (curType == EFMT_DT_TEST)
      yByte = video.lumaBypass;
    else
      yByte = video.lumaProc;
    codeByte = {1'b1, q.fv.f, q.fv.v, q.st == ST_EAV,
                q.fv.v ^ (q.st == ST_EAV),
                q.fv.f ^ (q.st == ST_EAV),
                q.fv.f ^ q.fv.v,
                q.fv.f ^ q.fv.v ^ (q.st == ST_EAV)};
    fillByte = q.cnt[0] ? EFMT_BLK_HI : EFMT_BLK_LO;
    adcWord  = q.adcPh ? video.adcB : video.adcA;
    adcByte  = q.regs.outFmt[0] ? adcWord[7:0] :
               adcWord[EFMT_ADC_W-1:EFMT_ADC_W-8];
  end

  always_comb
  begin
    next_q = q;
    // register writes
    if (wrEn)
    begin
      unique case (apbReq.paddr)
        EFMT_A_OUTFMT: next_q.regs.outFmt     = apbReq.pwdata[2:0];
        EFMT_A_LTYPE:  next_q.regs.lineType   = apbReq.pwdata[7:0];
        EFMT_A_GAIN:   next_q.regs.gain       = apbReq.pwdata[7:0];
        EFMT_A_OFFS:   next_q.regs.offset     = apbReq.pwdata[7:0];
        EFMT_A_GSTART: next_q.regs.gateStart  = apbReq.pwdata[9:0];
        EFMT_A_GSTOP:  next_q.regs.gateStop   = apbReq.pwdata[9:0];
        EFMT_A_CFG:    next_q.regs.lumaChroma = apbReq.pwdata[0];
        default:       next_q.regs = q.regs;
      endcase
    end
    // read data captured in the setup phase
    if (apbReq.psel && !apbReq.penable)
    begin
      unique case (apbReq.paddr)
        EFMT_A_OUTFMT: next_q.prdata = {29'h0, q.regs.outFmt};
        EFMT_A_LTYPE:  next_q.prdata = {24'h0, q.regs.lineType};
        EFMT_A_GAIN:   next_q.prdata = {24'h0, q.regs.gain};
        EFMT_A_OFFS:   next_q.prdata = {24'h0, q.regs.offset};
        EFMT_A_GSTART: next_q.prdata = {22'h0, q.regs.gateStart};
        EFMT_A_GSTOP:  next_q.prdata = {22'h0, q.regs.gateStop};
        EFMT_A_CFG:    next_q.prdata = {31'h0, q.regs.lumaChroma};
        EFMT_A_STAT:   next_q.prdata = {16'h0, q.st, q.fv.f, q.fv.v,
                                        2'b00, q.lineNo};
        default:       next_q.prdata = 32'h0000_0000;
      endcase
    end
    // line sequencer
    next_q.cnt = q.cnt + 11'h001;
    unique case (q.st)
      ST_EAV:
        if (q.cnt == CODE_LAST)
        begin
          next_q.st  = ST_BLANK;
          next_q.cnt = 11'h000;
        end
      ST_BLANK:
        if (q.cnt == BLANK_LAST)
        begin
          next_q.st  = ST_SAV;
          next_q.cnt = 11'h000;
        end
      ST_SAV:
        if (q.cnt == CODE_LAST)
        begin
          next_q.st  = ST_ACT;
          next_q.cnt = 11'h000;
        end
      ST_ACT:
        if (q.cnt == ACT_LAST)
        begin
          next_q.st     = ST_EAV;
          next_q.cnt    = 11'h000;
          next_q.lineNo = nextLine;
          next_q.fv     = nextFv;
        end
    endcase
    // output byte
    next_q.adcPh = testMode && q.regs.lumaChroma && !q.adcPh;
    next_q.aux   = testMode && adcWord[0];
    if (testMode)
      next_q.vob = adcByte;
    else
    begin
      unique case (q.st)
        ST_EAV, ST_SAV:
          if (!codesOn)
            next_q.vob = fillByte;
          else if (q.cnt == 11'h000)
            next_q.vob = EFMT_PRE_FF;
          else if (q.cnt == CODE_LAST)
            next_q.vob = codeByte;
          else
            next_q.vob = EFMT_PRE_00;
        ST_BLANK:
          next_q.vob = fillByte;
        ST_ACT:
          if (q.cnt[0])
            next_q.vob = yByte;
          else
            next_q.vob = video.chroma;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
      q <= Q_RST;
    else
      q <= next_q;
  end

  always_comb
  begin
    apbRsp.prdata  = q.prdata;
    apbRsp.pready  = 1'b1;
    apbRsp.pslverr = apbReq.psel && apbReq.penable && !addrHit;
  end

  assign videoOutputByteBus   = q.vob;
  assign auxRealtimeStatusPin = q.aux;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  logic eavStart;
  logic codeSlot;
  logic lineEnd;
  assign lineEnd  = (q.st == ST_ACT) && (q.cnt == ACT_LAST);
  assign eavStart = (q.st == ST_EAV) && (q.cnt == 11'h000);
  assign codeSlot = ((q.st == ST_EAV) || (q.st == ST_SAV)) &&
                    (q.cnt == CODE_LAST);

  sequence s_preamble;
    (q.vob == EFMT_PRE_FF) ##1 (q.vob == EFMT_PRE_00) ##1
    (q.vob == EFMT_PRE_00);
  endsequence

  sequence s_blank_pair;
    (q.vob == EFMT_BLK_LO) ##1 (q.vob == EFMT_BLK_HI);
  endsequence

  AST_PREAMBLE: assert property (
    eavStart && codesOn && $stable(q.regs) ##0 1 |=> s_preamble)
    else $error("preamble before code wrong");

  AST_EAV_CODE: assert property (
    codeSlot && codesOn && (q.st == ST_EAV) |=>
    (q.vob[7:4] == {1'b1, $past(q.fv.f), $past(q.fv.v), 1'b1}))
    else $error("eav code bits wrong");

  AST_SAV_CODE: assert property (
    codeSlot && codesOn && (q.st == ST_SAV) |=>
    (q.vob[7] && !q.vob[4] && (q.vob[5] == $past(q.fv.v))))
    else $error("sav code bits wrong");

  AST_BLANK_FILL: assert property (
    (q.st == ST_BLANK) && !q.cnt[0] && !testMode &&
    (q.cnt != BLANK_LAST) && $stable(q.regs.outFmt) ##1 !testMode
    |-> s_blank_pair)
    else $error("blanking pair wrong");

  AST_NO_CODES: assert property (
    codeSlot && (q.regs.outFmt == EFMT_OF_NOCODE) |=>
    (q.vob == EFMT_BLK_HI))
    else $error("code not replaced by blanking");

  AST_FV_HOLD: assert property (
    !((q.st == ST_ACT) && (q.cnt == ACT_LAST)) |=> $stable(q.fv))
    else $error("field or vblank bit changed mid line");

  AST_FIELD: assert property (
    q.fv.f == ((q.lineNo <= EFMT_F2_END) || (q.lineNo >= EFMT_F2_BEG)))
    else $error("field bit does not match line");

  AST_TEST_BYTE: assert property (
    testMode |=> (q.vob == $past(adcByte)) && (q.aux == $past(adcWord[0])))
    else $error("adc test byte wrong");

  AST_TEST_MUX: assert property (
    testMode && q.regs.lumaChroma && $stable(q.regs) ##1
    testMode |-> (q.adcPh != $past(q.adcPh)))
    else $error("adc mux not alternating");

  AST_RAW_Y: assert property (
    !testMode && (q.st == ST_ACT) && q.cnt[0] && efmt_is_raw(curType)
    |=> (q.vob == $past(rawY)))
    else $error("raw Y slot not composite");

  AST_BYPASS_Y: assert property (
    !testMode && (q.st == ST_ACT) && q.cnt[0] && (curType == EFMT_DT_TEST)
    |=> (q.vob == $past(video.lumaBypass)))
    else $error("test line Y slot not bypass luma");

  AST_CHROMA: assert property (
    !testMode && (q.st == ST_ACT) && !q.cnt[0] |=>
    (q.vob == $past(video.chroma)))
    else $error("chroma slot wrong");

  AST_AUX_IDLE: assert property (
    !testMode |=> !q.aux)
    else $error("aux pin set outside test output");

  AST_CODE_TOP: assert property (
    codeSlot && codesOn |=>
    (q.vob[7] && (q.vob[6] == $past(q.fv.f))))
    else $error("code bit 7 or field bit wrong");

  AST_STD_VBIT: assert property (
    lineEnd && (q.regs.outFmt != EFMT_OF_GATE) |=>
    (q.fv.v == ((q.lineNo <= EFMT_V1_END) ||
                ((q.lineNo >= EFMT_V2_BEG) && (q.lineNo <= EFMT_V2_END)))))
    else $error("standard vertical bit does not match line");

  AST_GATE_VBIT: assert property (
    lineEnd && (q.regs.outFmt == EFMT_OF_GATE) |=>
    (q.fv.v == !((q.lineNo >= $past(q.regs.gateStart)) &&
                 (q.lineNo <= $past(q.regs.gateStop)))))
    else $error("gate vertical bit does not match window");

  AST_LINE_WRAP: assert property (
    lineEnd && (q.lineNo == LINE_LAST) |=> (q.lineNo == EFMT_LINE_RST))
    else $error("line count did not wrap to line one");
endmodule // efmt_formatter
`default_nettype wire

/* testbench/efmt_codec_model.sv */
// Purpose: receiving codec model on the output byte bus
// Assumes: one byte sampled on each rising mclk edge
// Notes:   flags every timing code that follows FF 00 00
`default_nettype none
module efmt_codec_model
(
  input  wire logic       mclk,
  input  wire logic [7:0] busIn,
  output logic            codeStb,
  output logic [7:0]      code,
  output logic            codeEav
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] hist;
  always_ff @(posedge mclk)
  begin
    hist    <= {hist[15:0], busIn};
    codeStb <= (hist === 24'hFF_0000);
    if (hist === 24'hFF_0000)
    begin
      code    <= busIn;
      // low four bits not looked at
      codeEav <= busIn[4];
    end
  end
endmodule // efmt_codec_model
`default_nettype wire

/* testbench/testbench.sv */
// Purpose: self-checking bench of the expansion port formatter
// Assumes: short line timing, 525 lines a frame
// Notes:   registers reached through apb tasks
`default_nettype none
module testbench
  import efmt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned ACT   = 16;
  localparam int unsigned BLK   = 8;
  localparam int          LIMIT = 60000;
  localparam logic [7:0]  RA [8] = '{8'h00, 8'h04, 8'h08, 8'h0C,
                                     8'h10, 8'h14, 8'h18, 8'h20};
  localparam logic [32:0] RV [8] = '{33'h0, 33'hF0, 33'h80, 33'h80,
                                     33'h14, 33'h105, 33'h0,
                                     33'h1_0000_0000};
  localparam logic [3:0]  TYP [6] = '{4'h6, 4'hF, 4'h0, 4'hE, 4'h7, 4'h0};
  localparam logic [7:0]  GN [6] = '{8'h80, 8'h80, 8'h80, 8'h80, 8'h80,
                                     8'h40};
  localparam logic [7:0]  OF [6] = '{8'h80, 8'h80, 8'h80, 8'h80, 8'h80,
                                     8'h90};
  localparam logic [7:0]  YX [6] = '{8'h5A, 8'h3C, 8'h55, 8'h55, 8'h55,
                                     8'h3A};
  logic          mclk;
  logic          srst;
  efmt_apb_req_s apbReq;
  efmt_apb_rsp_s apbRsp;
  efmt_video_s   video;
  logic [7:0]    busOut;
  logic          aux;
  logic          codeStb;
  logic [7:0]    code;
  logic          codeEav;
  logic [31:0]   rd;
  logic          err;
  logic [8:0]    x;
  int            n;
  int            fail_count = 0;
  int            tests_run = 0;
  int            cycles = 0;

  efmt_formatter #(
    .ACT_BYTES  (ACT),
    .BLANK_BYTES(BLK),
    .LINES      (525)
  ) i_efmt_formatter (
    .mclk                (mclk),
    .srst                (srst),
    .apbReq              (apbReq),
    .apbRsp              (apbRsp),
    .video               (video),
    .videoOutputByteBus  (busOut),
    .auxRealtimeStatusPin(aux)
  );

  efmt_codec_model i_efmt_codec_model (
    .mclk   (mclk),
    .busIn  (busOut),
    .codeStb(codeStb),
    .code   (code),
    .codeEav(codeEav)
  );

  always #12.5 mclk = ~mclk;

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    apbReq.psel    <= 1'b1;
    apbReq.penable <= 1'b0;
    apbReq.pwrite  <= wr;
    apbReq.paddr   <= a;
    apbReq.pwdata  <= d;
    @(posedge mclk);
    apbReq.penable <= 1'b1;
    do
      @(posedge mclk);
    while (apbRsp.pready !== 1'b1);
    rd  = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq.psel    <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask

  task automatic step;
    @(posedge mclk);
    #1;
  endtask

  task automatic waitCode(input logic h);
    do
      step();
    while (!(codeStb === 1'b1 && codeEav === h));
  endtask

  function automatic logic [7:0] tcode(input logic f, v, h);
    return {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
  endfunction

  // one frame of codes against the line pattern
  task automatic frame(input logic gate, input int gs, input int ge);
    int         ln;
    logic       f;
    logic       v;
    logic [7:0] c;
    repeat (525)
    begin
      waitCode(1'b1);
      c = code;
      apb(1'b0, EFMT_A_STAT, 32'h0);
      ln = int'(rd[9:0]);
      f  = (ln <= 3) || (ln >= 266);
      v  = gate ? !(ln >= gs && ln <= ge)
                : (ln <= 19) || (ln >= 264 && ln <= 282);
      check(c, tcode(f, v, 1'b1));
      waitCode(1'b0);
      check(code, tcode(f, v, 1'b0));
    end
  endtask

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      fail_count++;
      summarize();
    end
  end

  initial
  begin
    mclk   = 1'b0;
    srst   = 1'b1;
    apbReq = '0;
    video  = '{8'h3C, 8'h5A, 8'h77, 8'h55, 10'h2A5, 10'h15A};
    repeat (8) @(posedge mclk);
    srst <= 1'b0;
    for (int k = 0; k < 8; k++)
    begin
      apb(1'b0, RA[k], 32'h0);
      check({err, rd}, RV[k]);
    end
    waitCode(1'b1);
    for (int i = 0; i < BLK; i++)
    begin
      check(busOut, i[0] ? 8'h10 : 8'h80);
      step();
    end
    check(busOut, EFMT_PRE_FF);
    frame(1'b0, 0, 0);
    apb(1'b1, EFMT_A_GSTART, 32'h0000_000A);
    apb(1'b1, EFMT_A_GSTOP, 32'h0000_0064);
    apb(1'b1, EFMT_A_OUTFMT, 32'h0000_0001);
    frame(1'b1, 10, 100);
    apb(1'b1, EFMT_A_OUTFMT, 32'h0000_0000);
    for (int k = 0; k < 6; k++)
    begin
      apb(1'b1, EFMT_A_LTYPE, {24'h0, TYP[k], TYP[k]});
      apb(1'b1, EFMT_A_GAIN, {24'h0, GN[k]});
      apb(1'b1, EFMT_A_OFFS, {24'h0, OF[k]});
      waitCode(1'b0);
      waitCode(1'b0);
      for (int i = 0; i < ACT; i++)
      begin
        check(busOut, i[0] ? YX[k] : 8'h77);
        step();
      end
      check(busOut, EFMT_PRE_FF);
    end
    apb(1'b1, EFMT_A_OUTFMT, 32'h0000_0002);
    repeat (4) step();
    n = 0;
    repeat (80)
    begin
      step();
      if (busOut === 8'hFF || codeStb === 1'b1)
        n++;
    end
    check(n, 0);
    apb(1'b1, EFMT_A_OUTFMT, 32'h0000_0004);
    repeat (2) step();
    check({aux, busOut}, 9'h1A9);
    apb(1'b1, EFMT_A_OUTFMT, 32'h0000_0005);
    repeat (2) step();
    check({aux, busOut}, 9'h1A5);
    apb(1'b1, EFMT_A_CFG, 32'h0000_0001);
    repeat (2) step();
    for (int i = 0; i < 40; i++)
    begin
      x = (busOut === 8'hA5) ? 9'h05A : 9'h1A5;
      step();
      check({aux, busOut}, x);
      check(codeStb, 1'b0);
    end
    summarize();
  end
endmodule // testbench
`default_nettype wire
